// file: adp_pkg.sv
`default_nettype none
// shared map, field layout and reset values for the adc dma progress and event unit
package adp_pkg;
	// register byte addresses on the avalon bus
	localparam logic [31:0] PEND_OFS = 32'h4000a810;
	// write-only clear alias of the pending register
	localparam logic [31:0] CLR_OFS = 32'h4000a818;
	localparam logic [31:0] EN_OFS = 32'h4000a850;
	localparam logic [31:0] CUR_OFS = 32'h4000d020;
	localparam logic [31:0] CNT_OFS = 32'h4000d024;
	// number of second-level event sources
	localparam int EV_W = 5;
	// event bit positions, shared by pending, clear and enable
	localparam int EV_OVF = 4;
	localparam int EV_SAT = 3;
	localparam int EV_FULL = 2;
	localparam int EV_HALF = 1;
	localparam int EV_DATA = 0;
	// buffer index width: results counted, not bytes
	localparam int CNT_W = 13;
	// next-address field starts at bit 1 (halfword address)
	localparam int CUR_LSB = 1;
	// reset values
	localparam logic [31:0] CUR_RST = 32'h20000000;
	localparam logic [CNT_W-1:0] CNT_RST = 13'h0000;
	localparam logic [EV_W-1:0] PEND_RST = 5'h00;
	localparam logic [EV_W-1:0] EN_RST = 5'h00;
	localparam logic [31:0] RD_UNMAPPED = 32'h00000000;
	// bus handshake states
	typedef enum logic [0:0] {BUS_IDLE, BUS_ACK} adp_bus_t;
endpackage : adp_pkg
`default_nettype wire

// file: adp_reg_if.sv
`timescale 1ns/1ps
`default_nettype none
// accepted register access from the bus slave to the register file
interface adp_reg_if;
	// write accepted this edge
	logic acc_wr;
	// byte address of the access
	logic [31:0] addr;
	logic [31:0] wdata;
	logic [3:0] be;
	// read value for addr, from the register file
	logic [31:0] rdata;
	modport slave (output acc_wr, addr, wdata, be, input rdata);
	modport regs (input acc_wr, addr, wdata, be, output rdata);
endinterface : adp_reg_if
`default_nettype wire

// file: adp_avs.sv
`timescale 1ns/1ps
`default_nettype none
// avalon-mm slave with one fixed wait state
module adp_avs (
	input wire logic clock,
	input wire logic srst,
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	adp_reg_if.slave regs
);
	import adp_pkg::*;

	// handshake state
	adp_bus_t state_r;

	// pass the held request straight through; master keeps it stable
	assign regs.addr = avs_address;
	assign regs.wdata = avs_writedata;
	assign regs.be = avs_byteenable;
	// write lands only on the edge where waitrequest is seen low
	assign regs.acc_wr = avs_write & (state_r == BUS_ACK);

	// idle -> ack for one cycle, then back to idle
	always_ff @(posedge clock) begin
		if (srst) begin
			state_r <= BUS_IDLE;
		end else begin
			case (state_r)
				BUS_IDLE: begin
					if (avs_read | avs_write) begin
						state_r <= BUS_ACK;
					end
				end
				BUS_ACK: begin
					state_r <= BUS_IDLE;
				end
				default: begin
					state_r <= BUS_IDLE;
				end
			endcase
		end
	end

	// waitrequest idles high, so the first cycle of a request always waits
	always_ff @(posedge clock) begin
		if (srst) begin
			avs_waitrequest <= 1'b1;
		end else begin
			avs_waitrequest <= !((state_r == BUS_IDLE) & (avs_read | avs_write));
		end
	end

	// read data captured one cycle early, stands during the ack cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			avs_readdata <= RD_UNMAPPED;
		end else if ((state_r == BUS_IDLE) & avs_read) begin
			avs_readdata <= regs.rdata;
		end
	end

	// bus handshake: waitrequest low for exactly one cycle per request
	sequence req_idle_s;
		(state_r == BUS_IDLE) && (avs_read || avs_write);
	endsequence
	sequence ack_once_s;
		##1 !avs_waitrequest ##1 avs_waitrequest;
	endsequence
	bus_ack_a: assert property (@(posedge clock) disable iff (srst) req_idle_s |-> ack_once_s)
		else $error("bus ack not one cycle after request");
endmodule : adp_avs
`default_nettype wire

// file: adp_dma_prog.sv
`timescale 1ns/1ps
`default_nettype none
// dma progress: next write address, stored count, buffer events
module adp_dma_prog #(
	parameter int CW = 13
) (
	input wire logic clock,
	input wire logic srst,
	input wire logic dma_load,
	input wire logic dma_reset,
	input wire logic dma_autowrap,
	input wire logic [CW:0] dma_base_addr,
	input wire logic [CW-1:0] buffer_length_results,
	input wire logic result_ready,
	input wire logic [15:0] result_data,
	output logic [CW-1:0] next_address_value,
	output logic [CW-1:0] results_written_value,
	output logic dma_active,
	output logic dma_overflow_status,
	output logic buffer_overflow_event,
	output logic buffer_full_event,
	output logic buffer_half_event,
	output logic ram_we,
	output logic [CW:0] ram_addr,
	output logic [15:0] ram_wdata
);
	// result accepted into the buffer this cycle
	logic store;
	logic [CW-1:0] cnt_inc;
	logic [CW-1:0] half_len;
	assign store = result_ready & dma_active;
	assign cnt_inc = results_written_value + 1'b1;
	assign half_len = buffer_length_results >> 1;

	// address and count; load and dma reset both restart at the base
	always_ff @(posedge clock) begin
		if (srst) begin
			dma_active <= 1'b0;
			results_written_value <= '0;
			next_address_value <= '0;
		end else if (dma_reset | dma_load) begin
			dma_active <= dma_load & !dma_reset;
			results_written_value <= '0;
			next_address_value <= dma_base_addr[CW:1];
		end else if (store) begin
			if (cnt_inc == buffer_length_results) begin
				// full: wrap or stop, count held at length when linear
				dma_active <= dma_autowrap;
				results_written_value <= dma_autowrap ? '0 : cnt_inc;
				next_address_value <= dma_autowrap ? dma_base_addr[CW:1] : next_address_value + 1'b1;
			end else begin
				results_written_value <= cnt_inc;
				next_address_value <= next_address_value + 1'b1;
			end
		end
	end

	always_ff @(posedge clock) begin
		if (srst | dma_reset) begin
			dma_overflow_status <= 1'b0;
		end else if (result_ready & !dma_active) begin
			dma_overflow_status <= 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (srst) begin
			buffer_overflow_event <= 1'b0;
			buffer_full_event <= 1'b0;
			buffer_half_event <= 1'b0;
		end else begin
			buffer_overflow_event <= result_ready & !dma_active;
			buffer_full_event <= store & (cnt_inc == buffer_length_results);
			buffer_half_event <= store & (half_len != '0) & (cnt_inc == half_len);
		end
	end

	// ram write port, one cycle behind the store
	always_ff @(posedge clock) begin
		if (srst) begin
			ram_we <= 1'b0;
			ram_addr <= '0;
			ram_wdata <= 16'h0000;
		end else begin
			ram_we <= store;
			ram_addr <= {next_address_value, 1'b0};
			ram_wdata <= result_data;
		end
	end

	ovf_set_a: assert property (@(posedge clock) disable iff (srst)
		result_ready && !dma_active && !dma_reset |=> dma_overflow_status && buffer_overflow_event)
		else $error("overflow not raised");
	ovf_hold_a: assert property (@(posedge clock) disable iff (srst)
		dma_overflow_status && !dma_reset |=> dma_overflow_status)
		else $error("overflow dropped without dma reset");
	cnt_step_a: assert property (@(posedge clock) disable iff (srst)
		store && !dma_load && !dma_reset && (cnt_inc != buffer_length_results)
		|=> results_written_value == $past(results_written_value) + 1'b1)
		else $error("count did not step");
endmodule : adp_dma_prog
`default_nettype wire

// file: adp_dma_irq.sv
`timescale 1ns/1ps
`default_nettype none
module adp_dma_irq (
	input wire logic clock,
	input wire logic srst,
	// avalon-mm register port, byte addressed
	input wire logic [31:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// dma controls from the surrounding adc
	input wire logic dma_load,
	input wire logic dma_reset,
	input wire logic dma_autowrap,
	input wire logic [adp_pkg::CNT_W:0] dma_base_addr,
	input wire logic [adp_pkg::CNT_W-1:0] buffer_length_results,
	// conversion results and gain stage
	input wire logic result_ready,
	input wire logic [15:0] result_data,
	input wire logic gain_saturation,
	// buffer ram write port
	output logic ram_we,
	output logic [adp_pkg::CNT_W:0] ram_addr,
	output logic [15:0] ram_wdata,
	// status toward the adc
	output logic dma_active,
	output logic dma_overflow_status,
	// peripheral-level request to the vectored controller
	output logic adc_irq
);
	import adp_pkg::*;

	// accepted register accesses
	adp_reg_if regs ();

	// progress values from the dma tracker
	logic [CNT_W-1:0] next_address_value;
	logic [CNT_W-1:0] results_written_value;
	// buffer event pulses from the dma tracker
	logic buffer_overflow_event;
	logic buffer_full_event;
	logic buffer_half_event;
	// gain saturation and data-ready pulses, taken as is
	logic gain_saturation_event;
	logic result_ready_event;

	// all five sources in flag order
	logic [EV_W-1:0] ev_set;
	// write-one-clear mask for this cycle
	logic [EV_W-1:0] ev_clr;
	// sticky pending flags
	logic [EV_W-1:0] adc_event_pending_r;
	// enables, same layout
	logic [EV_W-1:0] adc_event_enable_r;
	logic [EV_W-1:0] adc_event_enable_nxt;
	// decoded write targets
	logic wr_pend;
	logic wr_clr;
	logic wr_en;

	// bus slave: one wait state per access
	adp_avs u_avs (
		.clock(clock),
		.srst(srst),
		.avs_address(avs_address),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_writedata(avs_writedata),
		.avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.regs(regs.slave)
	);

	// dma tracker: address, count, overflow, thresholds
	adp_dma_prog #(
		.CW(CNT_W)
	) u_prog (
		.clock(clock),
		.srst(srst),
		.dma_load(dma_load),
		.dma_reset(dma_reset),
		.dma_autowrap(dma_autowrap),
		.dma_base_addr(dma_base_addr),
		.buffer_length_results(buffer_length_results),
		.result_ready(result_ready),
		.result_data(result_data),
		.next_address_value(next_address_value),
		.results_written_value(results_written_value),
		.dma_active(dma_active),
		.dma_overflow_status(dma_overflow_status),
		.buffer_overflow_event(buffer_overflow_event),
		.buffer_full_event(buffer_full_event),
		.buffer_half_event(buffer_half_event),
		.ram_we(ram_we),
		.ram_addr(ram_addr),
		.ram_wdata(ram_wdata)
	);

	// gain stage and data register events arrive as pulses already
	assign gain_saturation_event = gain_saturation;
	assign result_ready_event = result_ready;

	// collect sources in their flag positions
	always_comb begin
		ev_set = '0;
		ev_set[EV_OVF] = buffer_overflow_event;
		ev_set[EV_SAT] = gain_saturation_event;
		ev_set[EV_FULL] = buffer_full_event;
		ev_set[EV_HALF] = buffer_half_event;
		ev_set[EV_DATA] = result_ready_event;
	end

	// write decode; only byte lane 0 carries the five flags
	assign wr_pend = regs.acc_wr & (regs.addr == PEND_OFS) & regs.be[0];
	assign wr_clr = regs.acc_wr & (regs.addr == CLR_OFS) & regs.be[0];
	assign wr_en = regs.acc_wr & (regs.addr == EN_OFS) & regs.be[0];

	assign ev_clr = (wr_pend | wr_clr) ? regs.wdata[EV_W-1:0] : '0;

	// one sticky flag per source; a set in the clearing cycle wins
	generate
		for (genvar i = 0; i < EV_W; i++) begin : g_flag
			always_ff @(posedge clock) begin
				if (srst) begin
					adc_event_pending_r[i] <= PEND_RST[i];
				end else if (ev_set[i]) begin
					adc_event_pending_r[i] <= 1'b1;
				end else if (ev_clr[i]) begin
					adc_event_pending_r[i] <= 1'b0;
				end
			end
		end
	endgenerate

	assign adc_event_enable_nxt = wr_en ? regs.wdata[EV_W-1:0] : adc_event_enable_r;

	// enable register, plain read-write
	always_ff @(posedge clock) begin
		if (srst) begin
			adc_event_enable_r <= EN_RST;
		end else begin
			adc_event_enable_r <= adc_event_enable_nxt;
		end
	end

	// registered so the request output is glitch free; costs one cycle
	always_ff @(posedge clock) begin
		if (srst) begin
			adc_irq <= 1'b0;
		end else begin
			adc_irq <= |(adc_event_pending_r & adc_event_enable_r);
		end
	end

	// read mux; unmapped and write-only addresses read zero
	always_comb begin
		regs.rdata = RD_UNMAPPED;
		case (regs.addr)
			PEND_OFS: begin
				regs.rdata[EV_W-1:0] = adc_event_pending_r;
			end
			EN_OFS: begin
				regs.rdata[EV_W-1:0] = adc_event_enable_r;
			end
			CUR_OFS: begin
				regs.rdata = CUR_RST | (32'(next_address_value) << CUR_LSB);
			end
			CNT_OFS: begin
				regs.rdata[CNT_W-1:0] = results_written_value;
			end
			default: begin
				regs.rdata = RD_UNMAPPED;
			end
		endcase
	end

	// shared shape: a source pulse shows as its flag next cycle
	property flag_set_p(logic ev, logic flag);
		@(posedge clock) disable iff (srst) ev |=> flag;
	endproperty

	ovf_flag_a: assert property (flag_set_p(buffer_overflow_event, adc_event_pending_r[EV_OVF]))
		else $error("overflow flag not set");
	sat_flag_a: assert property (flag_set_p(gain_saturation_event, adc_event_pending_r[EV_SAT]))
		else $error("saturation flag not set");
	full_flag_a: assert property (flag_set_p(buffer_full_event, adc_event_pending_r[EV_FULL]))
		else $error("full flag not set");
	half_flag_a: assert property (flag_set_p(buffer_half_event, adc_event_pending_r[EV_HALF]))
		else $error("half flag not set");
	data_flag_a: assert property (flag_set_p(result_ready_event, adc_event_pending_r[EV_DATA]))
		else $error("data flag not set");

	flag_hold_a: assert property (@(posedge clock) disable iff (srst)
		(adc_event_pending_r[EV_SAT] && !ev_clr[EV_SAT]) |=> adc_event_pending_r[EV_SAT])
		else $error("saturation flag dropped without clear");
	// write one clears when no event
	flag_clear_a: assert property (@(posedge clock) disable iff (srst)
		(ev_clr[EV_HALF] && !ev_set[EV_HALF]) |=> !adc_event_pending_r[EV_HALF])
		else $error("half flag not cleared by write one");

	en_write_a: assert property (@(posedge clock) disable iff (srst)
		wr_en |=> adc_event_enable_r == $past(regs.wdata[EV_W-1:0]))
		else $error("enable register did not load");

	sequence pend_enabled_s;
		(adc_event_pending_r & adc_event_enable_r) != '0;
	endsequence
	irq_rise_a: assert property (@(posedge clock) disable iff (srst) pend_enabled_s |=> adc_irq)
		else $error("request missing while enabled flag pending");
	irq_fall_a: assert property (@(posedge clock) disable iff (srst)
		(adc_event_pending_r & adc_event_enable_r) == '0 |=> !adc_irq)
		else $error("request high with no enabled flag");
endmodule : adp_dma_irq
`default_nettype wire

// file: adp_far_model.sv
`timescale 1ns/1ps
`default_nettype none
// stand-in for the buffer ram and the top-level vectored controller
module adp_far_model (
	input wire logic clock,
	input wire logic ram_we,
	input wire logic [adp_pkg::CNT_W:0] ram_addr,
	input wire logic [15:0] ram_wdata,
	input wire logic adc_irq,
	input wire logic top_en,
	output logic irq_taken
);
	import adp_pkg::*;
	// halfword buffer, one slot per result
	logic [15:0] mem [0:8191];
	assign irq_taken = adc_irq & top_en;
	// store each result as the dma hands it over
	always_ff @(posedge clock) begin
		if (ram_we) begin
			mem[ram_addr[CNT_W:1]] <= ram_wdata;
		end
	end
endmodule : adp_far_model
`default_nettype wire

// file: tb_adc_dma_progress_and_irq_flags.sv
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the adc dma progress and event unit
module tb_adc_dma_progress_and_irq_flags;
	import adp_pkg::*;
	// one bus row: optional write, then a read back of the same place
	typedef struct packed {logic wr; logic [31:0] addr; logic [31:0] wdata; logic [3:0] be; logic [31:0] exp;} adp_row_t;
	localparam logic [31:0] UNMAP = 32'h4000a900;
	localparam adp_row_t ROWS [0:10] = '{
		'{1'b0, PEND_OFS, 32'h0, 4'hf, 32'h0},
		'{1'b0, EN_OFS, 32'h0, 4'hf, 32'h0},
		'{1'b0, CUR_OFS, 32'h0, 4'hf, 32'h20000000},
		'{1'b0, CNT_OFS, 32'h0, 4'hf, 32'h0},
		'{1'b0, UNMAP, 32'h0, 4'hf, 32'h0},
		'{1'b1, EN_OFS, 32'h1f, 4'hf, 32'h1f},
		'{1'b1, EN_OFS, 32'h0, 4'he, 32'h1f},
		'{1'b1, CUR_OFS, 32'hffff, 4'hf, 32'h20000000},
		'{1'b1, CNT_OFS, 32'hffff, 4'hf, 32'h0},
		'{1'b1, EN_OFS, 32'h0, 4'hf, 32'h0},
		'{1'b1, UNMAP, 32'hffffffff, 4'hf, 32'h0}};
	logic clock, srst, avs_read, avs_write, dma_load, dma_reset, dma_autowrap, irq_taken;
	logic result_ready, gain_saturation, avs_waitrequest, ram_we, dma_active, dma_overflow_status, adc_irq, top_en;
	logic [31:0] avs_address, avs_writedata, avs_readdata, q;
	logic [3:0] avs_byteenable;
	logic [CNT_W:0] dma_base_addr, ram_addr;
	logic [CNT_W-1:0] buffer_length_results;
	logic [15:0] result_data, ram_wdata;
	int mismatches = 0;
	int n_checks = 0;
	adp_dma_irq i_dut (.clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dma_load(dma_load),
		.dma_reset(dma_reset), .dma_autowrap(dma_autowrap), .dma_base_addr(dma_base_addr),
		.buffer_length_results(buffer_length_results), .result_ready(result_ready), .result_data(result_data),
		.gain_saturation(gain_saturation), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.dma_active(dma_active), .dma_overflow_status(dma_overflow_status), .adc_irq(adc_irq));
	adp_far_model i_far (.clock(clock), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
		.adc_irq(adc_irq), .top_en(top_en), .irq_taken(irq_taken));
	// free-running 100 mhz clock
	initial begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end
	// compare one value, count and report
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
		n_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask : chk
	// one avalon access; holds everything until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d, input logic [3:0] be);
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		avs_byteenable <= be;
		// no wait count assumed; a stuck slave is left to the watchdog
		do begin
			@(posedge clock);
		end while (avs_waitrequest !== 1'b0);
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		// a gap so the strobe is never raised in the edge that drops it
		@(posedge clock);
	endtask : bus
	task automatic rd(input logic [31:0] a, input logic [31:0] exp, input string what);
		bus(1'b0, a, 32'h0, 4'hf);
		chk(q, exp, what);
	endtask : rd
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d, 4'hf);
	endtask : wr
	// back-to-back results, then time for the registered flags
	task automatic res(input int n, input logic [15:0] v0);
		for (int i = 0; i < n; i++) begin
			result_ready <= 1'b1;
			result_data <= v0 + 16'(i);
			@(posedge clock);
		end
		result_ready <= 1'b0;
		repeat (3) @(posedge clock);
	endtask : res
	task automatic load;
		dma_load <= 1'b1;
		@(posedge clock);
		dma_load <= 1'b0;
		@(posedge clock);
	endtask : load
	task automatic do_reset;
		srst <= 1'b1;
		repeat (12) @(posedge clock);
		srst <= 1'b0;
		@(posedge clock);
	endtask : do_reset
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// watchdog: the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clock);
		mismatches++;
		wrap_up;
	end
	initial begin
		{avs_read, avs_write, dma_load, dma_reset, dma_autowrap, result_ready, gain_saturation} = '0;
		{avs_address, avs_writedata, dma_base_addr, buffer_length_results, result_data} = '0;
		avs_byteenable = 4'hf;
		top_en = 1'b1;
		srst = 1'b1;
		do_reset;
		foreach (ROWS[i]) begin
			if (ROWS[i].wr) bus(1'b1, ROWS[i].addr, ROWS[i].wdata, ROWS[i].be);
			rd(ROWS[i].addr, ROWS[i].exp, "register row");
		end
		$display("test register rows done");
		// linear fill of four results from byte offset 0x100
		dma_base_addr <= 14'h0100;
		buffer_length_results <= 13'h0004;
		load;
		chk(32'(dma_active), 32'h1, "active after load");
		res(2, 16'h1000);
		rd(PEND_OFS, 32'h03, "half and data");
		rd(CNT_OFS, 32'h2, "count two");
		rd(CUR_OFS, 32'h20000104, "address two");
		res(2, 16'h1002);
		rd(PEND_OFS, 32'h07, "full");
		rd(CNT_OFS, 32'h4, "count four");
		rd(CUR_OFS, 32'h20000108, "address past end");
		chk(32'(dma_active), 32'h0, "linear stop");
		for (int i = 0; i < 4; i++) chk(32'(i_far.mem[128+i]), 32'h1000 + 32'(i), "ram slot");
		res(1, 16'hbeef);
		chk(32'(dma_overflow_status), 32'h1, "overflow status");
		rd(PEND_OFS, 32'h17, "overflow flag");
		wr(PEND_OFS, 32'h0);
		rd(PEND_OFS, 32'h17, "zero write keeps");
		wr(PEND_OFS, 32'h05);
		rd(PEND_OFS, 32'h12, "one write clears");
		wr(CLR_OFS, 32'h12);
		rd(PEND_OFS, 32'h0, "clear alias");
		dma_reset <= 1'b1;
		@(posedge clock);
		dma_reset <= 1'b0;
		repeat (2) @(posedge clock);
		chk(32'(dma_overflow_status), 32'h0, "dma reset clears");
		$display("test linear fill done");
		// saturation flag and request masking
		gain_saturation <= 1'b1;
		@(posedge clock);
		gain_saturation <= 1'b0;
		rd(PEND_OFS, 32'h08, "saturation flag");
		chk(32'(adc_irq), 32'h0, "masked request");
		wr(EN_OFS, 32'h08);
		repeat (2) @(posedge clock);
		chk(32'(adc_irq), 32'h1, "enabled request");
		// software masks the whole peripheral at the top level only
		top_en <= 1'b0;
		@(posedge clock);
		chk(32'(irq_taken), 32'h0, "top level masked");
		top_en <= 1'b1;
		@(posedge clock);
		chk(32'(irq_taken), 32'h1, "top level unmasked");
		wr(EN_OFS, 32'h17);
		repeat (2) @(posedge clock);
		chk(32'(adc_irq), 32'h0, "other enables");
		wr(EN_OFS, 32'h08);
		wr(CLR_OFS, 32'h08);
		repeat (2) @(posedge clock);
		chk(32'(adc_irq), 32'h0, "cleared request");
		$display("test request done");
		// autowrap over a two-result buffer
		dma_autowrap <= 1'b1;
		buffer_length_results <= 13'h0002;
		load;
		res(3, 16'h2000);
		rd(CNT_OFS, 32'h1, "wrapped count");
		rd(CUR_OFS, 32'h20000102, "wrapped address");
		chk(32'(dma_active), 32'h1, "still active");
		rd(PEND_OFS, 32'h07, "wrap flags");
		chk(32'(i_far.mem[128]), 32'h2002, "overwritten slot");
		$display("test autowrap done");
		// reset in mid-run with a live request
		wr(EN_OFS, 32'h1f);
		repeat (2) @(posedge clock);
		chk(32'(adc_irq), 32'h1, "live request");
		do_reset;
		chk(32'(adc_irq), 32'h0, "request after reset");
		rd(EN_OFS, 32'h0, "enable after reset");
		rd(PEND_OFS, 32'h0, "pending after reset");
		rd(CUR_OFS, 32'h20000000, "address after reset");
		rd(CNT_OFS, 32'h0, "count after reset");
		$display("test mid-run reset done");
		wrap_up;
	end
endmodule : tb_adc_dma_progress_and_irq_flags
`default_nettype wire
